// ### tsgm_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; width and depth are parameters, depth a power of two.
module tsgm_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk_sys,   // System clock
  input  wire logic         reset_n,   // Async reset, active low
  input  wire logic [W-1:0] in_data,   // Write word
  input  wire logic         in_valid,  // Write request
  output logic              in_ready,  // Not full
  output logic      [W-1:0] out_data,  // Head word
  output logic              out_valid, // Not empty
  input  wire logic         out_ready  // Pop request
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic         push;
  logic         pop;

  // --------------------------------------------------------------------
  // Status and handshakes
  // --------------------------------------------------------------------
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem[rd_ptr[AW-1:0]];

  // Storage write
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr <= rd_ptr + (AW+1)'(1);
      end
    end
  end

endmodule

// ### tsgm_phy_clocking.sv
// Tri-speed GMII/MII clocking and pad logic between an 8-bit stream
// and an external PHY. Assumes every PHY pin, the 125 MHz reference and
// both PHY clocks arrive asynchronously and are sampled by clk_sys.

module tsgm_phy_clocking (
  input  wire logic       clk_sys,      // System clock, 10 MHz
  input  wire logic       reset_n,      // Async reset, active low
  input  wire logic [1:0] link_speed,   // Speed code, package values
  input  wire logic       ref_clk_125,  // Local reference clock pin
  input  wire logic       mii_tx_clk,   // PHY transmit clock pin
  input  wire logic       gmii_rx_clk,  // PHY receive clock pin
  input  wire logic [7:0] gmii_rxd,     // PHY receive data pins
  input  wire logic       gmii_rx_dv,   // PHY receive data valid pin
  input  wire logic       gmii_rx_er,   // PHY receive error pin
  output logic      [7:0] gmii_txd,     // Transmit data pad register
  output logic            gmii_tx_en,   // Transmit enable pad register
  output logic            gmii_tx_er,   // Transmit error pad register
  output logic            gmii_tx_clk,  // Forwarded transmit clock
  input  wire logic [7:0] s_tx_data,    // User transmit byte
  input  wire logic       s_tx_last,    // Last byte of frame
  input  wire logic       s_tx_err,     // Corrupt this byte
  input  wire logic       s_tx_valid,   // User byte offered
  output logic            s_tx_ready,   // FIFO can take a byte
  output logic            tx_clk_en,    // Transmit clock enable strobe
  output logic            tx_underrun,  // Frame starved, one pulse
  output logic      [7:0] m_rx_data,    // Received byte
  output logic            m_rx_err,     // Error seen in byte
  output logic            m_rx_valid,   // Received byte waiting
  input  wire logic       m_rx_ready,   // User takes the byte
  output logic            rx_clk_en,    // Receive clock enable strobe
  output logic            rx_drop       // Byte lost to stall, one pulse
);

  // ----------------------------------------------------------------------
  // Pin synchronisers, private to this instance
  // ----------------------------------------------------------------------
  logic [1:0]  tx_clk_pins;
  logic [10:0] rx_pins;
  logic        gig;

  assign gig = link_speed == tsgm_pkg::SPEED_1000;

  // Reference and PHY transmit clocks, never shared with others
  tsgm_pin_sync #(.W(2)) u_tx_clk_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  ({ref_clk_125, mii_tx_clk}),
    .pin_out (tx_clk_pins)
  );

  // Receive clock with its data so both stay aligned
  tsgm_pin_sync #(.W(11)) u_rx_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin_in  ({gmii_rx_clk, gmii_rx_dv, gmii_rx_er, gmii_rxd}),
    .pin_out (rx_pins)
  );

  // ----------------------------------------------------------------------
  // Transmit clock selection and edge detection
  // ----------------------------------------------------------------------
  logic tx_sel_clk;
  logic tx_sel_prev;
  logic tx_tick;
  logic tx_phase;
  logic tx_ce;

  // Sampled-level selector: reference at 1000, PHY clock below
  assign tx_sel_clk = gig ? tx_clk_pins[1] : tx_clk_pins[0];
  assign tx_tick    = tx_sel_clk && !tx_sel_prev;
  // Every edge at 1000, every second edge at 10/100
  assign tx_ce      = tx_tick && (gig || !tx_phase);

  // Previous selected clock level
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_sel_prev <= 1'b0;
    end else begin
      tx_sel_prev <= tx_sel_clk;
    end
  end

  // Nibble phase at MII speeds
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_phase <= 1'b0;
    end else if (gig) begin
      tx_phase <= 1'b0;
    end else if (tx_tick) begin
      tx_phase <= !tx_phase;
    end
  end

  // Registered enable strobe to the MAC
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_clk_en <= 1'b0;
    end else begin
      tx_clk_en <= tx_ce;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit FIFO
  // ----------------------------------------------------------------------
  tsgm_pkg::tsgm_byte_t fifo_in;
  tsgm_pkg::tsgm_byte_t fifo_out;
  logic                 fifo_valid;

  assign fifo_in = '{data: s_tx_data, last: s_tx_last, err: s_tx_err};

  // Bytes leave only on an enabled transmit edge
  tsgm_fifo #(
    .W     (tsgm_pkg::BYTE_T_W),
    .DEPTH (tsgm_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_data   (fifo_in),
    .in_valid  (s_tx_valid),
    .in_ready  (s_tx_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (tx_ce)
  );

  // ----------------------------------------------------------------------
  // Transmit frame tracking
  // ----------------------------------------------------------------------
  tsgm_pkg::tsgm_tx_state_t tx_state;
  tsgm_pkg::tsgm_tx_state_t next_tx_state;

  // Frame opens on a popped byte, closes on its last byte
  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      tsgm_pkg::TX_IDLE: begin
        if (tx_ce && fifo_valid && !fifo_out.last) begin
          next_tx_state = tsgm_pkg::TX_FRAME;
        end
      end
      tsgm_pkg::TX_FRAME: begin
        if (tx_ce && (!fifo_valid || fifo_out.last)) begin
          next_tx_state = tsgm_pkg::TX_IDLE;
        end
      end
      default: begin
        next_tx_state = tsgm_pkg::TX_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= tsgm_pkg::TX_IDLE;
    end else begin
      tx_state <= next_tx_state;
    end
  end

  // Starved mid-frame: FIFO empty on an enabled edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_underrun <= 1'b0;
    end else begin
      tx_underrun <= tx_ce && !fifo_valid
                     && (tx_state == tsgm_pkg::TX_FRAME);
    end
  end

  // ----------------------------------------------------------------------
  // Transmit pad registers
  // ----------------------------------------------------------------------
  tsgm_pkg::tsgm_gmii_t tx_pad;
  logic [3:0]           tx_hold;

  assign gmii_txd   = tx_pad.d;
  assign gmii_tx_en = tx_pad.en;
  assign gmii_tx_er = tx_pad.er;

  // Byte or low nibble on enable, high nibble on the next edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      tx_pad  <= '{d: tsgm_pkg::PAD_IDLE, en: 1'b0, er: 1'b0};
      tx_hold <= tsgm_pkg::NIB_IDLE;
    end else if (tx_ce) begin
      if (fifo_valid) begin
        tx_pad.en <= 1'b1;
        tx_pad.er <= fifo_out.err;
        tx_pad.d  <= gig ? fifo_out.data
                         : {tsgm_pkg::NIB_IDLE, fifo_out.data[3:0]};
        tx_hold   <= fifo_out.data[7:4];
      end else begin
        tx_pad  <= '{d: tsgm_pkg::PAD_IDLE, en: 1'b0, er: 1'b0};
        tx_hold <= tsgm_pkg::NIB_IDLE;
      end
    end else if (tx_tick) begin
      tx_pad.d <= {tsgm_pkg::NIB_IDLE, tx_hold};
    end
  end

  // ----------------------------------------------------------------------
  // Forwarded transmit clock
  // ----------------------------------------------------------------------
  // Registered inverse of the reference at 1000, held low below
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      gmii_tx_clk <= 1'b0;
    end else begin
      gmii_tx_clk <= gig && !tx_clk_pins[1];
    end
  end

  // ----------------------------------------------------------------------
  // Receive clock edge and pad sampling
  // ----------------------------------------------------------------------
  tsgm_pkg::tsgm_gmii_t rx_pad;
  logic                 rx_clk_prev;
  logic                 rx_tick;
  logic                 rx_tick_d;

  assign rx_tick = rx_pins[10] && !rx_clk_prev;

  // Receive clock history and delayed edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_clk_prev <= 1'b0;
      rx_tick_d   <= 1'b0;
    end else begin
      rx_clk_prev <= rx_pins[10];
      rx_tick_d   <= rx_tick;
    end
  end

  // Pad input registers take the pins on each receive edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_pad <= '{d: tsgm_pkg::PAD_IDLE, en: 1'b0, er: 1'b0};
    end else if (rx_tick) begin
      rx_pad <= '{d: rx_pins[7:0], en: rx_pins[9], er: rx_pins[8]};
    end
  end

  // ----------------------------------------------------------------------
  // Receive enable and nibble packing
  // ----------------------------------------------------------------------
  logic       rx_phase;
  logic       rx_ce;
  logic [3:0] rx_low;
  logic       rx_low_er;

  assign rx_ce = rx_tick_d && rx_pad.en && (gig || rx_phase);

  // Phase restarts while data valid is low
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_phase <= 1'b0;
    end else if (rx_tick_d) begin
      rx_phase <= rx_pad.en && !gig && !rx_phase;
    end
  end

  // Low nibble kept until its partner arrives
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_low    <= tsgm_pkg::NIB_IDLE;
      rx_low_er <= 1'b0;
    end else if (rx_tick_d && !rx_phase) begin
      rx_low    <= rx_pad.d[3:0];
      rx_low_er <= rx_pad.er;
    end
  end

  // Registered enable strobe to the MAC
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rx_clk_en <= 1'b0;
    end else begin
      rx_clk_en <= rx_ce;
    end
  end

  // ----------------------------------------------------------------------
  // Receive user stream
  // ----------------------------------------------------------------------
  // Byte held until taken; a new byte over a stalled one is dropped
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      m_rx_data  <= tsgm_pkg::PAD_IDLE;
      m_rx_err   <= 1'b0;
      m_rx_valid <= 1'b0;
      rx_drop    <= 1'b0;
    end else begin
      rx_drop <= rx_ce && m_rx_valid && !m_rx_ready;
      if (rx_ce && (!m_rx_valid || m_rx_ready)) begin
        m_rx_valid <= 1'b1;
        m_rx_data  <= gig ? rx_pad.d : {rx_pad.d[3:0], rx_low};
        m_rx_err   <= rx_pad.er || (!gig && rx_low_er);
      end else if (m_rx_ready) begin
        m_rx_valid <= 1'b0;
      end
    end
  end

endmodule

// ### tsgm_phy_clocking_chk.sv
// Port checker for the tri-speed PHY clocking block.
// Assumes it is bound by name to every instance of the top module.
module tsgm_phy_clocking_chk (
  input wire logic       clk_sys,     // System clock
  input wire logic       reset_n,     // Async reset, active low
  input wire logic [1:0] link_speed,  // Speed code
  input wire logic       ref_clk_125, // Reference pin
  input wire logic [7:0] gmii_txd,    // Transmit data pads
  input wire logic       gmii_tx_en,  // Transmit enable pad
  input wire logic       gmii_tx_er,  // Transmit error pad
  input wire logic       gmii_tx_clk, // Forwarded clock
  input wire logic       tx_clk_en,   // Transmit enable strobe
  input wire logic       tx_underrun, // Starvation pulse
  input wire logic [7:0] m_rx_data,   // Received byte
  input wire logic       m_rx_valid,  // Received byte waiting
  input wire logic       m_rx_ready,  // User takes byte
  input wire logic       rx_clk_en,   // Receive enable strobe
  input wire logic       rx_drop      // Lost byte pulse
);
  logic [2:0] ref_cnt; // Steady reference cycles at 1000
  logic       ref_q;   // Last reference sample

  // ----------------------------------------------------------------------
  // Helper logic
  // ----------------------------------------------------------------------
  // Count cycles the reference pin has held still at gigabit speed
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ref_q   <= 1'b0;
      ref_cnt <= 3'h0;
    end else begin
      ref_q <= ref_clk_125;
      if (ref_clk_125 != ref_q || link_speed != tsgm_pkg::SPEED_1000)
        ref_cnt <= 3'h0;
      else if (ref_cnt != 3'h7)
        ref_cnt <= ref_cnt + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // Synchroniser plus output register settle within four steady cycles
  fwd_clk_inv_a: assert property (
    ref_cnt >= 3'h4 && ref_clk_125 == ref_q |-> gmii_tx_clk == !ref_clk_125)
    else $error("forwarded clock not inverse of reference");
  fwd_clk_off_a: assert property (
    (link_speed != tsgm_pkg::SPEED_1000) [*3] |-> !gmii_tx_clk)
    else $error("forwarded clock active below gigabit");
  ce_pulse_a: assert property (
    tx_clk_en |=> !tx_clk_en)
    else $error("transmit enable longer than one cycle");
  pad_hold_a: assert property (
    $changed(gmii_tx_en) |-> tx_clk_en)
    else $error("transmit enable pad moved off an enabled edge");
  pad_idle_a: assert property (
    !gmii_tx_en |-> !gmii_tx_er && gmii_txd == tsgm_pkg::PAD_IDLE)
    else $error("idle pads not cleared");
  nib_upper_a: assert property (
    gmii_tx_en && link_speed != tsgm_pkg::SPEED_1000 |-> gmii_txd[7:4] == 4'h0)
    else $error("upper data pads used at nibble speed");
  starve_pulse_a: assert property (
    tx_underrun |-> (tx_clk_en || $past(tx_clk_en)) && !gmii_tx_en)
    else $error("underrun without an empty enabled edge");
  rx_en_rise_a: assert property (
    $rose(m_rx_valid) |-> rx_clk_en)
    else $error("receive byte without receive enable");
  rx_hold_a: assert property (
    m_rx_valid && !m_rx_ready |=> m_rx_valid && $stable(m_rx_data))
    else $error("receive byte not held while stalled");
  rx_drop_a: assert property (
    rx_drop |-> $past(m_rx_valid))
    else $error("drop pulse without a held byte");

  cover property (tx_clk_en && gmii_tx_en);
  cover property (tx_underrun);
  cover property ($rose(m_rx_valid));
  cover property (rx_drop);
endmodule

bind tsgm_phy_clocking tsgm_phy_clocking_chk CHK (.*);

// ### tsgm_phy_clocking_tb_top.sv
// Self-checking bench of the tri-speed PHY clocking block.
// Assumes the PHY model and the port checker are compiled alongside.
module tsgm_phy_clocking_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_sys, reset_n, ref_clk_125, tx_run, mii_tx_clk;
  logic       gmii_rx_clk, gmii_rx_dv, gmii_rx_er, gmii_tx_en, gmii_tx_er;
  logic       gmii_tx_clk, s_tx_last, s_tx_err, s_tx_valid, s_tx_ready;
  logic       tx_clk_en, tx_underrun, m_rx_err, m_rx_valid, m_rx_ready;
  logic       rx_clk_en, rx_drop;
  logic [1:0] link_speed;
  logic [7:0] gmii_rxd, gmii_txd, s_tx_data, m_rx_data;
  logic [8:0] exp_q[$], rx_q[$], fr_q[$];
  int         n_fail, compares, n_ce, n_rise, n_ref, n_under, n_drop;

  tsgm_phy_clocking DUT (.*);
  tsgm_phy_model    PHY (.*);

  // Clocks: system clock and free local reference
  always #50 clk_sys = ~clk_sys;
  always #800 ref_clk_125 = ~ref_clk_125;
  always @(posedge mii_tx_clk) n_rise++;
  always @(posedge ref_clk_125) n_ref++;

  // Event counters and receive collector
  always @(posedge clk_sys) begin
    if (tx_clk_en === 1'b1) n_ce++;
    if (tx_underrun === 1'b1) n_under++;
    if (rx_drop === 1'b1) n_drop++;
    if (m_rx_valid === 1'b1 && m_rx_ready === 1'b1)
      rx_q.push_back({m_rx_err, m_rx_data});
  end

  task automatic tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for n entries in capture (0) or receive (1) queue
  task automatic wait_n(input int which, input int n);
    int i;
    for (i = 0; i < 20000; i++) begin
      if ((which == 0 ? PHY.cap_q.size() : rx_q.size()) >= n) break;
      @(negedge clk_sys);
    end
    if (i == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  endtask

  // Offer one byte, hold until taken
  task automatic push(input logic [7:0] d, input logic l, input logic e);
    int i;
    @(negedge clk_sys);
    s_tx_data  = d;
    s_tx_last  = l;
    s_tx_err   = e;
    s_tx_valid = 1'b1;
    for (i = 0; i < 2000 && s_tx_ready !== 1'b1; i++) @(negedge clk_sys);
    if (i == 2000) begin
      n_fail++;
      tally_and_finish();
    end
    @(posedge clk_sys);
    exp_q.push_back({e, d});
  endtask

  // Send a frame of nb bytes and compare what the PHY saw
  task automatic tx_frame(input int nb);
    for (int i = 0; i < nb; i++)
      push(8'h3c + 8'(i * 8'h29), i == nb - 1, i == 1);
    @(negedge clk_sys);
    s_tx_valid = 1'b0;
    wait_n(0, nb);
    while (exp_q.size() > 0)
      cmp(16'(PHY.cap_q.pop_front()), 16'(exp_q.pop_front()));
  endtask

  task automatic set_speed(input logic [1:0] sp);
    @(negedge clk_sys);
    link_speed = sp;
    repeat (20) @(negedge clk_sys);
  endtask

  // Gigabit transmit on the reference, one enable per reference rise
  task automatic sc_tx_gig;
    set_speed(tsgm_pkg::SPEED_1000);
    n_ce  = 0;
    n_ref = 0;
    tx_frame(5);
    cmp(16'(n_ce >= n_ref - 1 && n_ce <= n_ref + 1), 16'h1);
    // Let the empty enabled edge close the pads before any speed change
    repeat (40) @(negedge clk_sys);
    cmp(16'(gmii_tx_en), 16'h0);
  endtask

  // Nibble transmit on the PHY clock, enable on every second rise
  task automatic sc_tx_mii(input logic [1:0] sp);
    set_speed(sp);
    tx_run = 1'b1;
    n_ce   = 0;
    n_rise = 0;
    tx_frame(4);
    tx_run = 1'b0;
    repeat (30) @(negedge clk_sys);
    cmp(16'(2 * n_ce >= n_rise - 1 && 2 * n_ce <= n_rise + 1), 16'h1);
    cmp(16'(gmii_tx_en), 16'h0);
  endtask

  // Fill until refused, then drain and starve mid-frame
  task automatic sc_fifo_full;
    int i;
    set_speed(tsgm_pkg::SPEED_100);
    for (i = 0; i < 40; i++) begin
      @(negedge clk_sys);
      s_tx_data  = 8'(i);
      s_tx_last  = 1'b0;
      s_tx_err   = 1'b0;
      s_tx_valid = 1'b1;
      if (s_tx_ready !== 1'b1) break;
      @(posedge clk_sys);
      exp_q.push_back({1'b0, 8'(i)});
    end
    // Hold the refused byte across one edge while full
    @(negedge clk_sys);
    s_tx_valid = 1'b0;
    cmp(16'(i), 16'(tsgm_pkg::FIFO_DEPTH));
    cmp(16'(s_tx_ready), 16'h0);
    n_under = 0;
    tx_run  = 1'b1;
    wait_n(0, i);
    while (exp_q.size() > 0)
      cmp(16'(PHY.cap_q.pop_front()), 16'(exp_q.pop_front()));
    repeat (40) @(negedge clk_sys);
    tx_run = 1'b0;
    cmp(16'(n_under), 16'h1);
    cmp(16'(PHY.cap_q.size()), 16'h0);
    repeat (20) @(negedge clk_sys);
  endtask

  // Receive frame at one speed, bytes and error flags compared
  task automatic sc_rx(input logic [1:0] sp);
    set_speed(sp);
    fr_q.delete();
    for (int i = 0; i < 3; i++) fr_q.push_back({i == 2, 8'ha5 ^ 8'(i * 8'h37)});
    PHY.rx_frame(fr_q, sp == tsgm_pkg::SPEED_1000);
    wait_n(1, 3);
    foreach (fr_q[i]) cmp(16'(rx_q.pop_front()), 16'(fr_q[i]));
  endtask

  // Stalled receiver keeps the first byte and reports the rest lost
  task automatic sc_rx_stall;
    set_speed(tsgm_pkg::SPEED_1000);
    m_rx_ready = 1'b0;
    n_drop     = 0;
    fr_q.delete();
    for (int i = 0; i < 3; i++) fr_q.push_back({1'b0, 8'h61 + 8'(i)});
    PHY.rx_frame(fr_q, 1'b1);
    repeat (20) @(negedge clk_sys);
    cmp(16'(n_drop), 16'h2);
    cmp(16'(m_rx_valid), 16'h1);
    m_rx_ready = 1'b1;
    wait_n(1, 1);
    repeat (10) @(negedge clk_sys);
    cmp(16'(rx_q.size()), 16'h1);
    cmp(16'(rx_q.pop_front()), 16'(fr_q[0]));
  endtask

  // Hang guard
  initial begin
    #9000000;
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    clk_sys     = 1'b0;
    reset_n     = 1'b0;
    ref_clk_125 = 1'b0;
    tx_run      = 1'b0;
    link_speed  = tsgm_pkg::SPEED_100;
    s_tx_data   = 8'h00;
    s_tx_last   = 1'b0;
    s_tx_err    = 1'b0;
    s_tx_valid  = 1'b0;
    m_rx_ready  = 1'b1;
    repeat (8) @(negedge clk_sys);
    cmp(16'({gmii_tx_en,gmii_tx_clk,m_rx_valid,s_tx_ready}), 16'h1);
    reset_n = 1'b1;
    sc_tx_mii(tsgm_pkg::SPEED_10);
    sc_tx_gig();
    sc_tx_mii(tsgm_pkg::SPEED_100);
    sc_fifo_full();
    sc_rx(tsgm_pkg::SPEED_10);
    sc_rx(tsgm_pkg::SPEED_100);
    sc_rx(tsgm_pkg::SPEED_1000);
    sc_rx_stall();
    tally_and_finish();
  end
endmodule

// ### tsgm_phy_model.sv
// Behavioural PHY on the far side of the GMII/MII pins.
// Assumes the bench calls rx_frame and reads cap_q by hierarchy.
module tsgm_phy_model (
  input  wire logic [1:0] link_speed,  // Speed code
  input  wire logic       tx_run,      // Let transmit clock run
  input  wire logic [7:0] gmii_txd,    // Transmit data pads
  input  wire logic       gmii_tx_en,  // Transmit enable pad
  input  wire logic       gmii_tx_er,  // Transmit error pad
  input  wire logic       gmii_tx_clk, // Forwarded clock
  output logic            mii_tx_clk,  // PHY transmit clock
  output logic            gmii_rx_clk, // PHY receive clock
  output logic      [7:0] gmii_rxd,    // Receive data
  output logic            gmii_rx_dv,  // Receive valid
  output logic            gmii_rx_er   // Receive error
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] cap_q[$]; // Captured {err, data}
  logic [3:0] lo_nib;   // First nibble held
  logic       lo_er;    // First nibble error
  logic       nib_ph;   // Second nibble due

  // Transmit clock, stands still low outside bursts
  initial begin
    mii_tx_clk = 1'b0;
    forever begin
      #400;
      if (tx_run || mii_tx_clk)
        mii_tx_clk = ~mii_tx_clk;
    end
  end

  // Gigabit capture on the forwarded clock
  always @(posedge gmii_tx_clk) begin
    if (link_speed == tsgm_pkg::SPEED_1000 && gmii_tx_en)
      cap_q.push_back({gmii_tx_er, gmii_txd});
  end

  // Nibble capture, low nibble first
  always @(posedge mii_tx_clk) begin
    if (link_speed == tsgm_pkg::SPEED_1000 || !gmii_tx_en) begin
      nib_ph = 1'b0;
    end else if (!nib_ph) begin
      lo_nib = gmii_txd[3:0];
      lo_er  = gmii_tx_er;
      nib_ph = 1'b1;
    end else begin
      cap_q.push_back({lo_er | gmii_tx_er, gmii_txd[3:0], lo_nib});
      nib_ph = 1'b0;
    end
  end

  // Idle receive lines
  initial begin
    gmii_rx_clk = 1'b0;
    gmii_rxd    = 8'h5a;
    gmii_rx_dv  = 1'b0;
    gmii_rx_er  = 1'b0;
  end

  // One receive clock period, data launched well clear of the rise
  task automatic rx_unit(input logic [8:0] u, input logic dv);
    gmii_rx_dv = dv;
    gmii_rxd   = u[7:0];
    gmii_rx_er = u[8];
    #200 gmii_rx_clk = 1'b1;
    #400 gmii_rx_clk = 1'b0;
    #200;
  endtask

  // Whole frame, then idle periods with toggling data lines
  task automatic rx_frame(input logic [8:0] q[$], input logic gig);
    foreach (q[i]) begin
      if (gig) begin
        rx_unit(q[i], 1'b1);
      end else begin
        rx_unit({1'b0, 4'h0, q[i][3:0]}, 1'b1);
        rx_unit({q[i][8], 4'h0, q[i][7:4]}, 1'b1);
      end
    end
    rx_unit({1'b0, ~gmii_rxd}, 1'b0);
    rx_unit({1'b0, ~gmii_rxd}, 1'b0);
  endtask
endmodule

// ### tsgm_pin_sync.sv
// Three-stage synchroniser for a group of pins from outside clk_sys.
// Assumes the group is sampled together so its bits stay aligned.
module tsgm_pin_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,  // System clock
  input  wire logic         reset_n,  // Async reset, active low
  input  wire logic [W-1:0] pin_in,   // Raw pins
  output logic      [W-1:0] pin_out   // Settled value
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // --------------------------------------------------------------------
  // Shift chain; the first stage feeds only the second
  // --------------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Accept a change once stages two and three agree
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      pin_out <= '0;
    end else if (stage2 == stage3) begin
      pin_out <= stage3;
    end
  end

endmodule

// ### tsgm_pkg.sv
// Shared constants and carrier types of the tri-speed PHY clocking block.
// Assumes a single system clock domain samples every PHY-facing pin.
package tsgm_pkg;

  // ----------------------------------------------------------------------
  // Speed codes and widths
  // ----------------------------------------------------------------------
  localparam logic [1:0] SPEED_10   = 2'h0;
  localparam logic [1:0] SPEED_100  = 2'h1;
  localparam logic [1:0] SPEED_1000 = 2'h2;

  localparam int BYTE_W      = 8;
  localparam int NIBBLE_W    = 4;
  localparam int FIFO_DEPTH  = 16;
  localparam int PIN_STAGES  = 3;

  // Reset values of pad registers and idle pins
  localparam logic [7:0] PAD_IDLE  = 8'h00;
  localparam logic [3:0] NIB_IDLE  = 4'h0;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  // One byte of a user stream
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       err;
  } tsgm_byte_t;

  // One set of GMII data pins
  typedef struct packed {
    logic [7:0] d;
    logic       en;
    logic       er;
  } tsgm_gmii_t;

  localparam int BYTE_T_W = $bits(tsgm_byte_t);
  localparam int GMII_T_W = $bits(tsgm_gmii_t);

  // Transmit frame tracker, one-hot
  typedef enum logic [1:0] {
    TX_IDLE  = 2'h1,
    TX_FRAME = 2'h2
  } tsgm_tx_state_t;

endpackage
